// [fidc_pkg.sv]
// Constants, types and carriers for the flash instruction host
package fidc_pkg;
  localparam int          ADDR_W             = 16;
  localparam int          DATA_W             = 8;
  localparam int          SEL_W              = 12;
  localparam int          PRI_W              = 8;
  localparam int          WIN_W              = 10;
  localparam logic [15:0] UNLOCK1_ADDR       = 16'h0555;
  localparam logic [15:0] UNLOCK2_ADDR       = 16'h0AAA;
  localparam logic [15:0] CMD_ADDR           = 16'h0555;
  localparam logic [15:0] EVEN_ADDR          = 16'h0000;
  localparam logic [7:0]  UNLOCK1_DATA       = 8'hAA;
  localparam logic [7:0]  UNLOCK2_DATA       = 8'h55;
  localparam logic [7:0]  OP_AUTOSELECT      = 8'h90;
  localparam logic [7:0]  OP_PROGRAM         = 8'hA0;
  localparam logic [7:0]  OP_ERASE_SETUP     = 8'h80;
  localparam logic [7:0]  OP_CHIP_CONFIRM    = 8'h10;
  localparam logic [7:0]  OP_SECTOR_CONFIRM  = 8'h30;
  localparam logic [7:0]  OP_SUSPEND         = 8'hB0;
  localparam logic [7:0]  OP_RESUME          = 8'h30;
  localparam logic [7:0]  OP_RESET           = 8'hF0;
  localparam logic [7:0]  OP_BYPASS          = 8'h20;
  localparam logic [7:0]  OP_BYPASS_EXIT1    = 8'h90;
  localparam logic [7:0]  OP_BYPASS_EXIT2    = 8'h00;
  localparam logic [1:0]  ID_LOW_BITS        = 2'h1;
  localparam logic [1:0]  PROT_LOW_BITS      = 2'h2;
  localparam int          MODE_ADDR_BIT      = 6;
  localparam int          ERR_BIT            = 5;
  localparam int          POLL_BIT           = 7;
  localparam int          CLK_MHZ            = 10;
  localparam int          ERASE_WINDOW_US    = 80;
  localparam logic [9:0]  ERASE_WINDOW_CYCLES = 10'(ERASE_WINDOW_US * CLK_MHZ);
  localparam logic [2:0]  SETUP_CYCLES       = 3'h1;
  localparam logic [2:0]  STROBE_CYCLES      = 3'h4;
  localparam logic [2:0]  HOLD_CYCLES        = 3'h1;
  localparam logic [11:0] SEL_RESET          = 12'h000;

  typedef enum logic [3:0] {
    CMD_READ, CMD_ID_READ, CMD_PROT_READ, CMD_PROGRAM, CMD_BYP_PROGRAM,
    CMD_CHIP_ERASE, CMD_SECTOR_ERASE, CMD_SECTOR_APPEND, CMD_SUSPEND,
    CMD_RESUME, CMD_RESET, CMD_BYPASS_ENTER, CMD_BYPASS_RESET
  } fidc_cmd_t;

  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} fidc_state_t;
  typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_HOLD} fidc_cyc_state_t;

  typedef struct packed {
    fidc_cmd_t   cmd;
    logic [15:0] addr;
    logic [7:0]  data;
    logic [11:0] sel;
  } fidc_req_t;

  typedef struct packed {
    logic        isRead;
    logic        last;
    logic        dcAddr;
    logic [15:0] addr;
    logic [7:0]  data;
  } fidc_step_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  dataOut;
    logic        dataOe;
    logic        controlPinZeroN;
    logic        readStrobeN;
  } fidc_pins_t;

  typedef struct packed {
    logic       refused;
    logic [7:0] data;
  } fidc_resp_t;

  typedef struct packed {
    logic needReset;
    logic bypass;
    logic erasing;
    logic suspended;
  } fidc_mode_t;

  localparam fidc_pins_t PINS_RESET = '{16'h0000, 8'h00, 1'b0, 1'b1, 1'b1};
  localparam fidc_mode_t MODE_RESET = '{1'b0, 1'b0, 1'b0, 1'b0};
endpackage

// [fidc_bus_cycle.sv]
// One timed write or read cycle on the flash bus pins
`timescale 1ns/100ps
module fidc_bus_cycle
  import fidc_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 startValid,
  output logic                      startReady,
  input  wire fidc_pkg::fidc_step_t step,
  input  wire logic [7:0]           busDataIn,
  output logic                      doneValid,
  output logic [7:0]                rdData,
  output fidc_pkg::fidc_pins_t      busPins
);
  fidc_cyc_state_t state_reg, state_next;
  logic [2:0]      cnt_reg, cnt_next;
  fidc_pins_t      pins_reg, pins_next;
  logic            isRead_reg, isRead_next;
  logic [7:0]      sync1_reg, sync2_reg;
  logic [7:0]      rdData_reg, rdData_next;
  logic            cntDone;

  assign cntDone    = cnt_reg == 3'h0;
  assign startReady = state_reg == CY_IDLE;
  assign doneValid  = state_reg == CY_HOLD && cntDone;
  assign rdData     = rdData_reg;
  assign busPins    = pins_reg;

  always_comb
  begin
    state_next  = state_reg;
    cnt_next    = cntDone ? cnt_reg : cnt_reg - 3'h1;
    pins_next   = pins_reg;
    isRead_next = isRead_reg;
    rdData_next = rdData_reg;
    unique case (state_reg)
      CY_IDLE:
        if (startValid)
        begin
          pins_next   = '{step.addr, step.data, !step.isRead, 1'b1, 1'b1};
          isRead_next = step.isRead;
          cnt_next    = SETUP_CYCLES - 3'h1;
          state_next  = CY_SETUP;
        end
      CY_SETUP:
        if (cntDone)
        begin
          pins_next.controlPinZeroN = isRead_reg;
          pins_next.readStrobeN     = !isRead_reg;
          cnt_next                  = STROBE_CYCLES - 3'h1;
          state_next                = CY_STROBE;
        end
      CY_STROBE:
        if (cntDone)
        begin
          pins_next.controlPinZeroN = 1'b1;
          pins_next.readStrobeN     = 1'b1;
          if (isRead_reg)
            rdData_next = sync2_reg;
          cnt_next   = HOLD_CYCLES - 3'h1;
          state_next = CY_HOLD;
        end
      CY_HOLD:
        if (cntDone)
        begin
          pins_next.dataOe = 1'b0;
          state_next       = CY_IDLE;
        end
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg  <= CY_IDLE;
      cnt_reg    <= 3'h0;
      pins_reg   <= PINS_RESET;
      isRead_reg <= 1'b0;
      sync1_reg  <= 8'h00;
      sync2_reg  <= 8'h00;
      rdData_reg <= 8'h00;
    end
    else
    begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      pins_reg   <= pins_next;
      isRead_reg <= isRead_next;
      sync1_reg  <= busDataIn;
      sync2_reg  <= sync1_reg;
      rdData_reg <= rdData_next;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  strobeExcl_a: assert property (
    !(!busPins.controlPinZeroN && !busPins.readStrobeN))
    else $error("write and read strobes low together");
  addrAtFall_a: assert property (
    $fell(busPins.controlPinZeroN) |-> $stable(busPins.addr) && busPins.dataOe)
    else $error("address not settled at write strobe fall");
  dataAtRise_a: assert property (
    $fell(busPins.controlPinZeroN) |-> (!busPins.controlPinZeroN && $stable(busPins.dataOut)
      && $stable(busPins.addr))[*4] ##1 (busPins.controlPinZeroN && busPins.dataOe))
    else $error("write data or strobe width wrong");
  readCapture_a: assert property (
    $rose(busPins.readStrobeN) |-> rdData_reg == $past(sync2_reg) && !busPins.dataOe)
    else $error("read data not captured at strobe end");
endmodule

// [fidc_host.sv]
// Host sequencer that issues flash instructions over the parallel bus pins
// Summary of operation
// - All instruction cycles are writes except the marked read cycles.
// - Don't-care instruction addresses are driven as even addresses.
// - Addressed sector select is held high during erase or verify cycles.
// - After identifier, protection read or error, reset is needed first.
// - Extra erase sectors must follow within 80 us of the last.
// - Bypass program is only legal after unlock bypass.
// - Bypass mode lasts until bypass reset; only then ordinary reads.
// - Caller must not run code from the array being instructed.
// - Prefixed instructions start with AAh at X555h then 55h at XAAAh.
// - Identifier read cycle drives A6,A1,A0 as 0,0,1 with primary select.
`timescale 1ns/100ps
module fidc_host
  import fidc_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                cmdValid,
  output logic                     cmdReady,
  input  wire fidc_pkg::fidc_req_t cmdReq,
  output logic                     respValid,
  output fidc_pkg::fidc_resp_t     resp,
  output fidc_pkg::fidc_mode_t     modeStatus,
  output fidc_pkg::fidc_pins_t     busPins,
  input  wire logic [7:0]          busDataIn,
  output logic [7:0]               primarySectorSelects,
  output logic [3:0]               secondarySectorSelects
);
  fidc_state_t state_reg, state_next;
  fidc_req_t   req_reg, req_next;
  logic [2:0]  idx_reg, idx_next;
  fidc_mode_t  mode_reg, mode_next;
  logic [9:0]  window_reg, window_next;
  logic [11:0] sel_reg, sel_next;
  logic        respValid_reg, respValid_next;
  fidc_resp_t  resp_reg, resp_next;
  fidc_step_t  curStep;
  logic        cycReady, cycDone, cmdOk, accept, finish, errSeen, pollDone, rstErr;
  logic [7:0]  cycData;

  function automatic fidc_step_t mk(input logic rd, input logic lst, input logic dc,
                                    input logic [15:0] a, input logic [7:0] d);
    mk = '{rd, lst, dc, a, d};
  endfunction

  function automatic logic isCmd(input fidc_req_t r, input fidc_cmd_t c);
    isCmd = r.cmd == c;
  endfunction

  function automatic fidc_step_t stepOf(input fidc_req_t r, input logic [2:0] i);
    logic [15:0] idAddr;
    logic [15:0] protAddr;
    logic        uTwo;
    idAddr   = {r.addr[15:7], 1'b0, r.addr[5:2], ID_LOW_BITS};
    protAddr = {r.addr[15:7], 1'b0, r.addr[5:2], PROT_LOW_BITS};
    uTwo     = i == 3'h1 || i == 3'h4;
    // Unlock pair ahead of each prefixed command
    stepOf   = uTwo ? mk(1'b0, 1'b0, 1'b0, UNLOCK2_ADDR, UNLOCK2_DATA)
                    : mk(1'b0, 1'b0, 1'b0, UNLOCK1_ADDR, UNLOCK1_DATA);
    unique case (r.cmd)
      CMD_READ:
        stepOf = mk(1'b1, 1'b1, 1'b0, r.addr, 8'h00);
      CMD_ID_READ:
        if (i == 3'h2)
          stepOf = mk(1'b0, 1'b0, 1'b0, CMD_ADDR, OP_AUTOSELECT);
        else if (i == 3'h3)
          stepOf = mk(1'b1, 1'b1, 1'b0, idAddr, 8'h00);
      CMD_PROT_READ:
        if (i == 3'h2)
          stepOf = mk(1'b0, 1'b0, 1'b0, CMD_ADDR, OP_AUTOSELECT);
        else if (i == 3'h3)
          stepOf = mk(1'b1, 1'b1, 1'b0, protAddr, 8'h00);
      CMD_PROGRAM:
        if (i == 3'h2)
          stepOf = mk(1'b0, 1'b0, 1'b0, CMD_ADDR, OP_PROGRAM);
        else if (i == 3'h3)
          stepOf = mk(1'b0, 1'b1, 1'b0, r.addr, r.data);
      CMD_BYP_PROGRAM:
        stepOf = i == 3'h0 ? mk(1'b0, 1'b0, 1'b1, EVEN_ADDR, OP_PROGRAM)
                           : mk(1'b0, 1'b1, 1'b0, r.addr, r.data);
      CMD_CHIP_ERASE, CMD_SECTOR_ERASE:
        if (i == 3'h2)
          stepOf = mk(1'b0, 1'b0, 1'b0, CMD_ADDR, OP_ERASE_SETUP);
        else if (i == 3'h5)
          stepOf = isCmd(r, CMD_CHIP_ERASE)
                 ? mk(1'b0, 1'b1, 1'b0, CMD_ADDR, OP_CHIP_CONFIRM)
                 : mk(1'b0, 1'b1, 1'b0, r.addr, OP_SECTOR_CONFIRM);
      CMD_SECTOR_APPEND:
        stepOf = mk(1'b0, 1'b1, 1'b0, r.addr, OP_SECTOR_CONFIRM);
      CMD_SUSPEND:
        stepOf = mk(1'b0, 1'b1, 1'b1, EVEN_ADDR, OP_SUSPEND);
      CMD_RESUME:
        stepOf = mk(1'b0, 1'b1, 1'b1, EVEN_ADDR, OP_RESUME);
      CMD_RESET:
        stepOf = mk(1'b0, 1'b1, 1'b1, EVEN_ADDR, OP_RESET);
      CMD_BYPASS_ENTER:
        if (i == 3'h2)
          stepOf = mk(1'b0, 1'b1, 1'b0, CMD_ADDR, OP_BYPASS);
      CMD_BYPASS_RESET:
        stepOf = i == 3'h0 ? mk(1'b0, 1'b0, 1'b1, EVEN_ADDR, OP_BYPASS_EXIT1)
                           : mk(1'b0, 1'b1, 1'b1, EVEN_ADDR, OP_BYPASS_EXIT2);
      default:
        stepOf = mk(1'b0, 1'b1, 1'b1, EVEN_ADDR, OP_RESET);
    endcase
  endfunction

  function automatic logic cmdAllowed(input fidc_req_t r, input fidc_mode_t m,
                                      input logic winOpen);
    logic any;
    any        = |r.sel;
    cmdAllowed = 1'b0;
    unique case (r.cmd)
      CMD_READ:
        cmdAllowed = any && !m.needReset && !m.bypass;
      CMD_ID_READ:
        cmdAllowed = (|r.sel[PRI_W-1:0]) && !m.bypass;
      CMD_PROT_READ, CMD_PROGRAM:
        cmdAllowed = any && !m.bypass;
      CMD_BYP_PROGRAM:
        cmdAllowed = any && m.bypass;
      CMD_CHIP_ERASE, CMD_SECTOR_ERASE, CMD_BYPASS_ENTER:
        cmdAllowed = any && !m.bypass && !m.erasing;
      CMD_SECTOR_APPEND:
        cmdAllowed = any && winOpen && m.erasing && !m.suspended;
      CMD_SUSPEND:
        cmdAllowed = any && m.erasing && !m.suspended;
      CMD_RESUME:
        cmdAllowed = any && m.suspended;
      CMD_RESET:
        cmdAllowed = any && !m.bypass;
      CMD_BYPASS_RESET:
        cmdAllowed = any && m.bypass;
      default:
        cmdAllowed = 1'b0;
    endcase
  endfunction

  fidc_bus_cycle u_cycle (
    .clk        (clk),
    .reset      (reset),
    .startValid (state_reg == ST_ISSUE),
    .startReady (cycReady),
    .step       (curStep),
    .busDataIn  (busDataIn),
    .doneValid  (cycDone),
    .rdData     (cycData),
    .busPins    (busPins)
  );

  assign curStep  = stepOf(req_reg, idx_reg);
  assign cmdReady = state_reg == ST_IDLE;
  assign cmdOk    = cmdAllowed(cmdReq, mode_reg, window_reg != 10'h000);
  assign accept   = cmdValid && cmdReady && cmdOk;
  assign finish   = state_reg == ST_WAIT && cycDone && curStep.last;
  assign errSeen  = finish && isCmd(req_reg, CMD_READ) && mode_reg.erasing
                    && !mode_reg.suspended && cycData[ERR_BIT];
  assign pollDone = finish && isCmd(req_reg, CMD_READ) && mode_reg.erasing
                    && !mode_reg.suspended && cycData[POLL_BIT];
  assign rstErr   = finish && isCmd(req_reg, CMD_RESET) && mode_reg.needReset;

  assign state_next = accept ? ST_ISSUE
                    : state_reg == ST_ISSUE && cycReady ? ST_WAIT
                    : state_reg == ST_WAIT && cycDone ? (curStep.last ? ST_IDLE : ST_ISSUE)
                    : state_reg;
  assign req_next   = accept ? cmdReq : req_reg;
  assign idx_next   = accept ? 3'h0
                    : state_reg == ST_WAIT && cycDone && !curStep.last ? idx_reg + 3'h1
                    : idx_reg;
  assign sel_next   = accept ? cmdReq.sel : finish ? SEL_RESET : sel_reg;
  assign mode_next  = '{
    (finish && (isCmd(req_reg, CMD_ID_READ) || isCmd(req_reg, CMD_PROT_READ)))
      || errSeen || (mode_reg.needReset && !(finish && isCmd(req_reg, CMD_RESET))),
    (finish && isCmd(req_reg, CMD_BYPASS_ENTER))
      || (mode_reg.bypass && !(finish && isCmd(req_reg, CMD_BYPASS_RESET))),
    (finish && isCmd(req_reg, CMD_SECTOR_ERASE))
      || (mode_reg.erasing && !pollDone && !rstErr),
    (finish && isCmd(req_reg, CMD_SUSPEND))
      || (mode_reg.suspended && !(finish && isCmd(req_reg, CMD_RESUME)) && !rstErr)};
  assign window_next = finish && (isCmd(req_reg, CMD_SECTOR_ERASE)
                       || isCmd(req_reg, CMD_SECTOR_APPEND)) ? ERASE_WINDOW_CYCLES
                     : window_reg != 10'h000 ? window_reg - 10'h001 : 10'h000;
  assign respValid_next = finish || (cmdValid && cmdReady && !cmdOk);
  assign resp_next      = finish ? fidc_resp_t'{1'b0, cycData} : fidc_resp_t'{1'b1, 8'h00};

  assign respValid              = respValid_reg;
  assign resp                   = resp_reg;
  assign modeStatus             = mode_reg;
  assign primarySectorSelects   = sel_reg[PRI_W-1:0];
  assign secondarySectorSelects = sel_reg[SEL_W-1:PRI_W];

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg     <= ST_IDLE;
      req_reg       <= '0;
      idx_reg       <= 3'h0;
      mode_reg      <= MODE_RESET;
      window_reg    <= 10'h000;
      sel_reg       <= SEL_RESET;
      respValid_reg <= 1'b0;
      resp_reg      <= '0;
    end
    else
    begin
      state_reg     <= state_next;
      req_reg       <= req_next;
      idx_reg       <= idx_next;
      mode_reg      <= mode_next;
      window_reg    <= window_next;
      sel_reg       <= sel_next;
      respValid_reg <= respValid_next;
      resp_reg      <= resp_next;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  unlockPair_a: assert property (
    state_reg == ST_ISSUE && idx_reg == 3'h0 && !curStep.last && !curStep.dcAddr
    |-> curStep.addr == UNLOCK1_ADDR && curStep.data == UNLOCK1_DATA
        ##[1:20] state_reg == ST_ISSUE && curStep.addr == UNLOCK2_ADDR
        && curStep.data == UNLOCK2_DATA)
    else $error("unlock pair not issued first");
  evenAddr_a: assert property (
    state_reg == ST_ISSUE && curStep.dcAddr |-> !curStep.addr[0])
    else $error("don't-care address is odd");
  selActive_a: assert property (
    !busPins.controlPinZeroN || !busPins.readStrobeN |-> sel_reg != SEL_RESET)
    else $error("strobe without sector select");
  idAddr_a: assert property (
    state_reg == ST_ISSUE && isCmd(req_reg, CMD_ID_READ) && curStep.isRead
    |-> !curStep.addr[MODE_ADDR_BIT] && curStep.addr[1:0] == ID_LOW_BITS
        && sel_reg[PRI_W-1:0] != 8'h00)
    else $error("identifier read address or select wrong");
  readAfterId_a: assert property (
    cmdValid && cmdReady && cmdReq.cmd == CMD_READ && mode_reg.needReset
    |=> respValid && resp.refused && state_reg == ST_IDLE)
    else $error("read accepted before reset");
  bypassOnly_a: assert property (
    cmdValid && cmdReady && cmdReq.cmd == CMD_BYP_PROGRAM && !mode_reg.bypass
    |=> respValid && resp.refused)
    else $error("bypass program accepted outside bypass");
  bypassHold_a: assert property (
    mode_reg.bypass && !(finish && isCmd(req_reg, CMD_BYPASS_RESET)) |=> mode_reg.bypass)
    else $error("bypass mode left without bypass reset");
  appendWindow_a: assert property (
    cmdValid && cmdReady && cmdReq.cmd == CMD_SECTOR_APPEND && window_reg == 10'h000
    |=> respValid && resp.refused)
    else $error("sector appended after window closed");
  suspendOnly_a: assert property (
    accept && cmdReq.cmd == CMD_SUSPEND |-> mode_reg.erasing && !mode_reg.suspended)
    else $error("suspend issued without sector erase");
endmodule

// [fidc_flash_model.sv]
// Behavioural flash device answering the host's bus pins
`timescale 1ns/100ps
module fidc_flash_model
  import fidc_pkg::*;
#(
  parameter logic [7:0] ID_CODE   = 8'h5A, // Arbitrary identifier value
  parameter logic [7:0] PROT_MASK = 8'h02
)
(
  input  wire fidc_pkg::fidc_pins_t busPins,
  input  wire logic [7:0]           primarySectorSelects,
  input  wire logic [3:0]           secondarySectorSelects,
  output logic [7:0]                busDataIn,
  output int                        oddCount
);
  logic [7:0]  mem [256];
  logic [15:0] pa;
  logic [7:0]  lastOut;
  int          seq;
  logic        idMode, bypass, erasing, suspended;
  wire         picked = |primarySectorSelects || |secondarySectorSelects;
  wire  [11:0] low12  = pa[11:0];
  wire  [7:0]  prot   = {7'h00, |(PROT_MASK & primarySectorSelects)};

  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h3C;
    {seq, oddCount, idMode, bypass, erasing, suspended} = '0;
    lastOut = 8'h00;
  end

  // Sequence position advances on each completed write strobe
  task automatic decode(input logic [7:0] d);
    if (pa[0] && low12 != 12'h555 && seq != 3 && seq != 10)
      oddCount++;
    case (seq)
      0: if (bypass && d == 8'hA0) seq = 10;
         else if (bypass && d == 8'h90) seq = 11;
         else if (!bypass && d == 8'hAA && low12 == 12'h555) seq = 1;
         else if (d == 8'hB0 && erasing && !suspended) suspended = 1'b1;
         else if (d == 8'h30 && suspended) suspended = 1'b0;
         else if (d == 8'hF0 && !bypass) idMode = 1'b0;
      1: seq = (d == 8'h55 && low12 == 12'hAAA) ? 2 : 0;
      2:
      begin
        seq = (d == 8'hA0) ? 3 : (d == 8'h80) ? 4 : 0;
        if (d == 8'h90) idMode = 1'b1;
        if (d == 8'h20) bypass = 1'b1;
      end
      3, 10:
      begin
        mem[pa[7:0]] = d;
        seq = 0;
      end
      4: seq = (d == 8'hAA) ? 5 : 0;
      5: seq = (d == 8'h55) ? 6 : 0;
      6:
      begin
        seq = 0;
        if (d == 8'h10 || d == 8'h30) mem = '{default: 8'hFF};
        erasing = (d == 8'h30);
      end
      11:
      begin
        seq = 0;
        if (d == 8'h00) bypass = 1'b0;
      end
      default: seq = 0;
    endcase
  endtask

  always @(negedge busPins.controlPinZeroN)
    if (picked) pa = busPins.addr;

  always @(posedge busPins.controlPinZeroN)
    if (picked) decode(busPins.dataOut);

  always @(negedge busPins.readStrobeN)
  begin
    if (idMode && busPins.addr[1:0] == 2'b01) lastOut = ID_CODE;
    else if (idMode && busPins.addr[1:0] == 2'b10) lastOut = prot;
    else if (erasing && !suspended) lastOut = 8'h80;
    else lastOut = mem[busPins.addr[7:0]];
    erasing = erasing && suspended;
    busDataIn = lastOut;
  end

  // Released bus shows a changed value, never the last byte
  always @(posedge busPins.readStrobeN)
    busDataIn = ~lastOut;
endmodule

// [test_flash_instruction_decoder.sv]
// Self-checking bench for the flash instruction host
`timescale 1ns/100ps
module test_flash_instruction_decoder;
  import fidc_pkg::*;
  localparam logic [7:0] ID_CODE   = 8'h5A; // Arbitrary identifier value
  localparam logic [7:0] PROT_MASK = 8'h02;
  logic       clk, reset, cmdValid, cmdReady, respValid;
  fidc_req_t  cmdReq;
  fidc_resp_t resp;
  fidc_mode_t modeStatus;
  fidc_pins_t busPins;
  logic [7:0] busDataIn, primarySectorSelects;
  logic [3:0] secondarySectorSelects;
  int         fail_count, total_checks, seed, oddCount, a, d, s;
  int         expMem [256];
  int         nr, byp, ers, sus;
  longint     lastErase;

  fidc_host u_dut (.clk(clk), .reset(reset), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdReq(cmdReq), .respValid(respValid), .resp(resp), .modeStatus(modeStatus),
    .busPins(busPins), .busDataIn(busDataIn), .primarySectorSelects(primarySectorSelects),
    .secondarySectorSelects(secondarySectorSelects));
  fidc_flash_model #(.ID_CODE(ID_CODE), .PROT_MASK(PROT_MASK)) u_flash (.busPins(busPins),
    .primarySectorSelects(primarySectorSelects), .busDataIn(busDataIn),
    .secondarySectorSelects(secondarySectorSelects), .oddCount(oddCount));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Reference model: acceptance, read data and mode per command
  task automatic predict(input fidc_cmd_t c, input int a, d, s, output int rf, dt);
    int ok;
    dt = -1;
    case (c)
      CMD_READ:                          ok = !nr && !byp;
      CMD_ID_READ:                       ok = !byp && (s & 255) != 0;
      CMD_PROT_READ, CMD_PROGRAM:        ok = !byp;
      CMD_BYP_PROGRAM, CMD_BYPASS_RESET: ok = byp;
      CMD_SUSPEND:                       ok = ers && !sus;
      CMD_RESUME:                        ok = sus;
      CMD_SECTOR_APPEND:                 ok = ers && !sus && ($time - lastErase < 80000);
      CMD_RESET:                         ok = !byp;
      default:                           ok = !byp && !ers;
    endcase
    rf = !(ok && s != 0);
    if (rf)
      dt = 0;
    else
      case (c)
        CMD_READ:
        begin
          dt = (ers && !sus) ? 8'h80 : expMem[a & 255];
          ers = ers && sus;
        end
        CMD_ID_READ:
        begin
          dt = ID_CODE;
          nr = 1;
        end
        CMD_PROT_READ:
        begin
          dt = (PROT_MASK & s) != 0;
          nr = 1;
        end
        CMD_PROGRAM, CMD_BYP_PROGRAM: expMem[a & 255] = d & 255;
        CMD_CHIP_ERASE, CMD_SECTOR_ERASE:
        begin
          expMem = '{default: 255};
          ers = (c == CMD_SECTOR_ERASE);
          lastErase = $time;
        end
        CMD_SECTOR_APPEND: lastErase = $time;
        CMD_SUSPEND: sus = 1;
        CMD_RESUME: sus = 0;
        CMD_RESET:
        begin
          sus = nr ? 0 : sus;
          ers = nr ? 0 : ers;
          nr = 0;
        end
        CMD_BYPASS_ENTER: byp = 1;
        CMD_BYPASS_RESET: byp = 0;
        default: ;
      endcase
  endtask

  task automatic run(input fidc_cmd_t c, input int a, d, s);
    int rf, dt, n;
    predict(c, a, d, s, rf, dt);
    cmdReq <= '{c, a[15:0], d[7:0], s[11:0]};
    cmdValid <= 1'b1;
    do @(posedge clk); while (cmdReady !== 1'b1);
    cmdValid <= 1'b0;
    for (n = 0; n < 200 && respValid !== 1'b1; n++)
      @(posedge clk);
    check(n < 200 && resp.refused === rf[0], "answer or refusal wrong");
    if (dt >= 0) check(resp.data === dt[7:0], "read data wrong");
    @(posedge clk);
    check(modeStatus === fidc_mode_t'({nr[0], byp[0], ers[0], sus[0]}), "mode wrong");
  endtask

  initial
  begin
    {fail_count, total_checks, nr, byp, ers, sus, lastErase} = '0;
    seed = 32'h56DA;
    cmdValid = 1'b0;
    cmdReq = '0;
    reset = 1'b1;
    for (int i = 0; i < 256; i++)
      expMem[i] = i ^ 'h3C;
    repeat (6) @(posedge clk);
    check(cmdReady === 1'b1 && modeStatus === MODE_RESET && busPins === PINS_RESET,
      "reset state wrong");
    reset <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 5; i++)
    begin
      a = $random(seed);
      d = $random(seed);
      s = 1 << ({$random(seed)} % 12);
      run(CMD_PROGRAM, a, d, s);
      run(CMD_READ, a, 0, s);
    end
    run(CMD_READ, 5, 0, 0);
    run(CMD_ID_READ, 0, 0, 12'h800);
    run(CMD_ID_READ, 16'h1234, 0, 1);
    run(CMD_READ, 5, 0, 1);
    run(CMD_RESET, 0, 0, 1);
    run(CMD_PROT_READ, 0, 0, 2);
    run(CMD_RESET, 0, 0, 2);
    run(CMD_PROT_READ, 0, 0, 4);
    run(CMD_RESET, 0, 0, 4);
    run(CMD_BYP_PROGRAM, 7, 8'h11, 1);
    run(CMD_BYPASS_ENTER, 0, 0, 1);
    run(CMD_BYP_PROGRAM, 7, 8'h11, 1);
    run(CMD_READ, 7, 0, 1);
    run(CMD_BYPASS_RESET, 0, 0, 1);
    run(CMD_READ, 7, 0, 1);
    run(CMD_SUSPEND, 0, 0, 1);
    run(CMD_RESUME, 0, 0, 1);
    run(CMD_SECTOR_ERASE, 16'h0100, 0, 1);
    run(CMD_SECTOR_APPEND, 16'h0200, 0, 2);
    repeat (810) @(posedge clk);
    run(CMD_SECTOR_APPEND, 16'h0300, 0, 4);
    run(CMD_SUSPEND, 0, 0, 1);
    run(CMD_SUSPEND, 0, 0, 1);
    run(CMD_READ, 9, 0, 2);
    run(CMD_PROGRAM, 9, 8'h42, 2);
    run(CMD_READ, 9, 0, 2);
    run(CMD_RESUME, 0, 0, 1);
    run(CMD_READ, 9, 0, 1);
    run(CMD_CHIP_ERASE, 0, 0, 1);
    run(CMD_READ, 9, 0, 1);
    run(CMD_BYPASS_ENTER, 0, 0, 1);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    check(modeStatus === MODE_RESET && cmdReady === 1'b1, "mode kept over reset");
    reset <= 1'b0;
    @(posedge clk);
    check(oddCount === 0, "odd don't-care address");
    tally_and_finish();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
endmodule
